// File: hdl/dsp_addr_pkg.sv
// Shared constants and types for the operand address and repeat block.
// Assumes a 16-bit data path and a 32-bit classic Wishbone register port.
package dsp_addr_pkg;

  // ----------------------------------------------------------------
  // Widths and instruction word fields
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int PAGE_W = 9;
  localparam int OFFS_W = 7;
  localparam int SEL_W = 3;
  localparam int AUX_N = 8;
  localparam int SHORT_IMM_W = 8;
  localparam int UPD_LSB = 4;
  localparam int LOAD_SEL_BIT = 3;
  localparam int SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WAIT = 8'h08;
  localparam logic [7:0] REG_AUX_BASE = 8'h20;
  localparam logic [7:0] REG_AUX_END = 8'h40;
  localparam int AUX_IDX_LSB = 2;
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_SEL_LSB = 16;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_ACTIVE_BIT = 16;
  localparam int STAT_HOLD_BIT = 17;
  localparam int WAIT_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and memory map limits
  // ----------------------------------------------------------------
  localparam logic [2:0] WAIT_RESET = 3'h7;
  localparam logic [15:0] ONCHIP_TOP = 16'h0800;

  // ----------------------------------------------------------------
  // Enumerations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DIRECT, MODE_INDIRECT, MODE_IMMEDIATE, MODE_REGISTER
  } addr_mode_t;

  typedef enum logic [2:0] {
    UPD_NONE, UPD_INC, UPD_DEC, UPD_ADD_IDX, UPD_SUB_IDX,
    UPD_REV_ADD, UPD_REV_SUB, UPD_SPARE
  } aux_update_t;

  typedef struct packed {
    addr_mode_t mode;
    logic long_imm;
    logic is_repeat;
    logic [15:0] word;
  } prog_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic addr_valid;
    logic data_valid;
  } op_result_t;

endpackage

// File: hdl/aux_addr_update.sv
// Post-access update of one auxiliary address register.
// Pure combinational; the caller applies the result after the access.
`timescale 1ns/1ps
`default_nettype none

module aux_addr_update (
  // Current pointer, index register and update code
  input wire logic [15:0] cur,
  input wire logic [15:0] idx,
  input wire dsp_addr_pkg::aux_update_t code,
  // Updated pointer
  output logic [15:0] next_addr
);

  logic [15:0] cur_rev;
  logic [15:0] idx_rev;
  logic [15:0] sum_rev;
  logic [15:0] diff_rev;
  logic [15:0] sum_fwd;
  logic [15:0] diff_fwd;

  // ----------------------------------------------------------------
  // Bit reversal, so the carry runs from the top bit downward
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_rev
    assign cur_rev[i] = cur[15-i];
    assign idx_rev[i] = idx[15-i];
    assign sum_fwd[i] = sum_rev[15-i];
    assign diff_fwd[i] = diff_rev[15-i];
  end

  assign sum_rev = cur_rev + idx_rev;
  assign diff_rev = cur_rev - idx_rev;

  // Update selection; plain steps wrap at 16 bits
  always_comb begin
    case (code)
      dsp_addr_pkg::UPD_INC: next_addr = cur + 16'h0001;
      dsp_addr_pkg::UPD_DEC: next_addr = cur - 16'h0001;
      dsp_addr_pkg::UPD_ADD_IDX: next_addr = cur + idx;
      dsp_addr_pkg::UPD_SUB_IDX: next_addr = cur - idx;
      dsp_addr_pkg::UPD_REV_ADD: next_addr = sum_fwd;
      dsp_addr_pkg::UPD_REV_SUB: next_addr = diff_fwd;
      default: next_addr = cur;
    endcase
  end

endmodule

`default_nettype wire

// File: hdl/dsp_operand_address_and_repeat.sv
// Operand address generation and repeat control for a 16-bit DSP core.
// Assumes a program word stream with decoded mode sideband, memory read
// data one cycle after an address, and a classic Wishbone master.
//
// Function
// - direct address is page pointer over seven instruction offset bits
// - indirect address comes from aux register picked by 3-bit selector
// - indirect offers six post updates incl. bit-reversed add and subtract
// - aux update in the same cycle; selector changes only after access
// - short immediate from instruction field, long from second word
// - register mode takes a 16-bit core register value, no address
// - repeat loads counter from memory word or 8-bit immediate
// - counter value N gives N+1 executions of a next one-word instruction; a two-word one runs once
// - core reset clears the repeat counter
// - all interrupts held off from repeat decode to loop end
// - each repeated iteration with an on-chip operand completes in one cycle
// - next program word is prefetched while current one executes
// - off-chip operand access adds extra cycles
// - one-word and two-word instruction forms are both decoded
`timescale 1ns/1ps
`default_nettype none

module dsp_operand_address_and_repeat (
  // Clock and synchronous reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Program word stream
  input wire logic PROG_VALID,
  input wire dsp_addr_pkg::prog_t PROG_WORD,
  output logic PROG_READY,
  // Operand sources
  input wire logic [15:0] MEM_RDATA,
  input wire logic [15:0] REG_OPERAND,
  // Operand result and interrupt hold
  output dsp_addr_pkg::op_result_t OP_RESULT,
  output logic INT_HOLD,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O
);

  typedef enum logic [2:0] {
    S_DECODE, S_LONG, S_LOAD_RPT, S_REPEAT, S_WAIT
  } state_t;

  state_t state;
  state_t ret_state;
  state_t target;
  logic [2:0] wait_cnt;
  logic [2:0] wait_states;
  logic [8:0] page_ptr;
  logic [2:0] aux_sel;
  logic [15:0] aux_regs [8];
  logic [15:0] repeat_counter;
  logic armed;
  dsp_addr_pkg::prog_t pf;
  dsp_addr_pkg::prog_t held;
  dsp_addr_pkg::prog_t exec;
  logic pf_full;
  logic next_pf_full;
  logic take;
  logic consume;
  logic issue;
  logic iter;
  logic last_iter;
  logic iter_done;
  logic mem_access;
  logic off_chip;
  logic hw_aux_we;
  logic [15:0] cur_aux;
  logic [15:0] eff_addr;
  logic [15:0] aux_next;
  logic wb_req;
  logic wb_wr;
  logic aux_hit;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_new;
  logic [31:0] aux_new;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Issue decode
  // ----------------------------------------------------------------
  // Current instruction, addresses and step control
  always_comb begin
    exec = pf;
    if (state == S_REPEAT || state == S_LONG) begin
      exec = held;
    end
    cur_aux = aux_regs[aux_sel];
    mem_access = exec.mode == dsp_addr_pkg::MODE_DIRECT ||
                 exec.mode == dsp_addr_pkg::MODE_INDIRECT;
    if (exec.mode == dsp_addr_pkg::MODE_INDIRECT) begin
      eff_addr = cur_aux;
    end else begin
      eff_addr = {page_ptr, exec.word[dsp_addr_pkg::OFFS_W-1:0]};
    end
    consume = (state == S_DECODE || state == S_LONG) && pf_full;
    issue = (state == S_DECODE && pf_full && !pf.long_imm) ||
            (state == S_LONG && pf_full) || state == S_REPEAT;
    iter = (armed && !exec.is_repeat && consume && issue) ||
           state == S_REPEAT;
    last_iter = iter && repeat_counter == 16'h0000;
    iter_done = last_iter || (iter && state == S_LONG);
    off_chip = issue && mem_access && eff_addr >= dsp_addr_pkg::ONCHIP_TOP;
    hw_aux_we = issue && exec.mode == dsp_addr_pkg::MODE_INDIRECT;
    case (state)
      S_DECODE: begin
        if (pf.long_imm) begin
          target = S_LONG;
        end else if (pf.is_repeat && mem_access) begin
          target = S_LOAD_RPT;
        end else if (iter && !last_iter) begin
          target = S_REPEAT;
        end else begin
          target = S_DECODE;
        end
      end
      S_REPEAT: target = last_iter ? S_DECODE : S_REPEAT;
      default: target = S_DECODE;
    endcase
  end

  aux_addr_update u_aux_update (
    .cur(cur_aux),
    .idx(aux_regs[0]),
    .code(dsp_addr_pkg::aux_update_t'(exec.word[dsp_addr_pkg::UPD_LSB +: 3])),
    .next_addr(aux_next)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // State, wait-state stall and held instruction
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state <= S_DECODE;
      ret_state <= S_DECODE;
      wait_cnt <= 3'h0;
      held <= '0;
    end else if (state == S_WAIT) begin
      if (wait_cnt == 3'h0) begin
        state <= ret_state;
      end else begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end else begin
      if (state == S_DECODE && pf_full) begin
        held <= pf;
      end
      if (off_chip) begin
        state <= S_WAIT;
        ret_state <= target;
        wait_cnt <= wait_states;
      end else if (issue || consume || state == S_LOAD_RPT) begin
        state <= target;
      end
    end
  end

  // Repeat counter, arming and interrupt hold
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      repeat_counter <= 16'h0000;
      armed <= 1'b0;
      INT_HOLD <= 1'b0;
    end else if (issue && exec.is_repeat && state == S_DECODE) begin
      INT_HOLD <= 1'b1;
      armed <= exec.mode == dsp_addr_pkg::MODE_IMMEDIATE;
      if (exec.mode == dsp_addr_pkg::MODE_IMMEDIATE) begin
        repeat_counter <= {8'h00, exec.word[7:0]};
      end
    end else if (state == S_LOAD_RPT) begin
      repeat_counter <= MEM_RDATA;
      armed <= 1'b1;
    end else if (iter) begin
      armed <= 1'b0;
      if (iter_done) begin
        INT_HOLD <= 1'b0;
        repeat_counter <= 16'h0000;
      end else begin
        repeat_counter <= repeat_counter - 16'h0001;
      end
    end
  end

  // Operand result, one pulse per issued access
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      OP_RESULT <= '0;
    end else begin
      OP_RESULT.addr_valid <= 1'b0;
      OP_RESULT.data_valid <= 1'b0;
      if (issue) begin
        case (exec.mode)
          dsp_addr_pkg::MODE_IMMEDIATE: begin
            if (state == S_LONG) begin
              OP_RESULT.data <= pf.word;
            end else begin
              OP_RESULT.data <= {8'h00, exec.word[7:0]};
            end
            OP_RESULT.data_valid <= !exec.is_repeat;
          end
          dsp_addr_pkg::MODE_REGISTER: begin
            OP_RESULT.data <= REG_OPERAND;
            OP_RESULT.data_valid <= 1'b1;
          end
          default: begin
            OP_RESULT.addr <= eff_addr;
            OP_RESULT.addr_valid <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Prefetch slot
  // ----------------------------------------------------------------
  assign take = PROG_VALID && PROG_READY;
  assign next_pf_full = (pf_full && !consume) || take;

  // Fills while the current instruction executes
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      pf <= '0;
      pf_full <= 1'b0;
      PROG_READY <= 1'b0;
    end else begin
      if (take) begin
        pf <= PROG_WORD;
      end
      pf_full <= next_pf_full;
      PROG_READY <= !next_pf_full;
    end
  end

  // ----------------------------------------------------------------
  // Register file and Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
  assign aux_hit = WB_ADR_I >= dsp_addr_pkg::REG_AUX_BASE &&
                   WB_ADR_I < dsp_addr_pkg::REG_AUX_END;

  // Read value decode
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[dsp_addr_pkg::CTRL_PAGE_LSB +: 9] = page_ptr;
    ctrl_rd[dsp_addr_pkg::CTRL_SEL_LSB +: 3] = aux_sel;
    // Byte-lane merged write values for control and the addressed aux reg
    ctrl_new = merge(ctrl_rd, WB_DAT_I, WB_SEL_I);
    aux_new = merge({16'h0000,
                     aux_regs[WB_ADR_I[dsp_addr_pkg::AUX_IDX_LSB +: 3]]},
                    WB_DAT_I, WB_SEL_I);
    rd_val = 32'h0000_0000;
    if (WB_ADR_I == dsp_addr_pkg::REG_CTRL) begin
      rd_val = ctrl_rd;
    end else if (WB_ADR_I == dsp_addr_pkg::REG_STATUS) begin
      rd_val[dsp_addr_pkg::STAT_CNT_LSB +: 16] = repeat_counter;
      rd_val[dsp_addr_pkg::STAT_ACTIVE_BIT] = armed || state == S_REPEAT;
      rd_val[dsp_addr_pkg::STAT_HOLD_BIT] = INT_HOLD;
    end else if (WB_ADR_I == dsp_addr_pkg::REG_WAIT) begin
      rd_val[dsp_addr_pkg::WAIT_LSB +: 3] = wait_states;
    end else if (aux_hit) begin
      rd_val[15:0] = aux_regs[WB_ADR_I[dsp_addr_pkg::AUX_IDX_LSB +: 3]];
    end
  end

  // Bus handshake, ack one cycle after the request
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req) begin
        WB_DAT_O <= rd_val;
      end
    end
  end

  // Page pointer, selector and wait states; hardware update wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      page_ptr <= 9'h000;
      aux_sel <= 3'h0;
      wait_states <= dsp_addr_pkg::WAIT_RESET;
    end else begin
      if (wb_wr && WB_ADR_I == dsp_addr_pkg::REG_CTRL) begin
        page_ptr <= ctrl_new[dsp_addr_pkg::CTRL_PAGE_LSB +: 9];
        aux_sel <= ctrl_new[dsp_addr_pkg::CTRL_SEL_LSB +: 3];
      end
      if (wb_wr && WB_ADR_I == dsp_addr_pkg::REG_WAIT && WB_SEL_I[0]) begin
        wait_states <= WB_DAT_I[2:0];
      end
      if (hw_aux_we && exec.word[dsp_addr_pkg::LOAD_SEL_BIT]) begin
        aux_sel <= exec.word[dsp_addr_pkg::SEL_LSB +: 3];
      end
    end
  end

  // Auxiliary registers, post-modified after each indirect access
  for (genvar i = 0; i < dsp_addr_pkg::AUX_N; i++) begin : g_aux
    always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
        aux_regs[i] <= 16'h0000;
      end else if (hw_aux_we && aux_sel == 3'(i)) begin
        aux_regs[i] <= aux_next;
      end else if (wb_wr && aux_hit &&
                   WB_ADR_I[dsp_addr_pkg::AUX_IDX_LSB +: 3] == 3'(i)) begin
        aux_regs[i] <= aux_new[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [16:0] iter_seen;
  logic [16:0] loaded_n;

  // Iteration tally for the loop count check
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      iter_seen <= 17'h00000;
      loaded_n <= 17'h00000;
    end else begin
      if (state == S_LOAD_RPT) begin
        loaded_n <= {1'b0, MEM_RDATA};
      end else if (issue && exec.is_repeat && state == S_DECODE) begin
        loaded_n <= {9'h000, exec.word[7:0]};
      end
      if (iter) begin
        iter_seen <= armed ? 17'h00001 : iter_seen + 17'h00001;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  direct_addr_a: assert property (issue && !off_chip &&
    exec.mode == dsp_addr_pkg::MODE_DIRECT |=> OP_RESULT.addr_valid &&
    OP_RESULT.addr == {$past(page_ptr), $past(exec.word[6:0])})
    else $error("direct address wrong");
  indirect_addr_a: assert property (hw_aux_we |=>
    OP_RESULT.addr == $past(cur_aux)) else $error("indirect address wrong");
  aux_post_a: assert property (hw_aux_we |=>
    aux_regs[$past(aux_sel)] == $past(aux_next))
    else $error("aux update lost");
  short_imm_a: assert property (issue && state == S_DECODE &&
    !exec.is_repeat && exec.mode == dsp_addr_pkg::MODE_IMMEDIATE |=>
    OP_RESULT.data_valid && OP_RESULT.data == {8'h00, $past(pf.word[7:0])})
    else $error("short immediate wrong");
  long_imm_a: assert property (state == S_LONG && pf_full &&
    !held.is_repeat && held.mode == dsp_addr_pkg::MODE_IMMEDIATE |=>
    OP_RESULT.data_valid &&
    OP_RESULT.data == $past(pf.word)) else $error("long immediate wrong");
  reg_mode_a: assert property (issue &&
    exec.mode == dsp_addr_pkg::MODE_REGISTER |=> OP_RESULT.data_valid &&
    !OP_RESULT.addr_valid && OP_RESULT.data == $past(REG_OPERAND))
    else $error("register operand wrong");
  rpt_imm_a: assert property (issue && state == S_DECODE &&
    exec.is_repeat && exec.mode == dsp_addr_pkg::MODE_IMMEDIATE |=>
    repeat_counter == {8'h00, $past(exec.word[7:0])})
    else $error("repeat load wrong");
  loop_count_a: assert property (last_iter |=>
    iter_seen == loaded_n + 17'h00001) else $error("iteration count wrong");
  reset_clear_a: assert property (disable iff (1'b0) !RESET_N |=>
    repeat_counter == 16'h0000 && !INT_HOLD) else $error("no reset clear");
  int_hold_a: assert property (state == S_REPEAT ||
    state == S_LOAD_RPT |-> INT_HOLD) else $error("interrupts open in loop");
  one_cycle_a: assert property (state == S_REPEAT &&
    !off_chip && !last_iter |=> state == S_REPEAT && issue)
    else $error("repeat iteration stalled");
  prefetch_a: assert property (state == S_WAIT && !pf_full &&
    !take |=> PROG_READY) else $error("no prefetch during execute");
  ext_wait_a: assert property (off_chip && wait_states == 3'h0
    |=> state == S_WAIT ##1 state != S_WAIT) else $error("no wait cycle");
  loop_end_a: assert property (last_iter && !off_chip
    |=> !INT_HOLD && state == S_DECODE) else $error("loop did not end");

  repeat_run_c: cover property (state == S_REPEAT [*3] ##1 !INT_HOLD);
  long_form_c: cover property (state == S_LONG ##1 OP_RESULT.data_valid);
  off_chip_c: cover property (off_chip ##1 state == S_WAIT);
  rev_update_c: cover property (hw_aux_we &&
    exec.word[6:4] == 3'h5);

endmodule

`default_nettype wire

// File: dv/tb_dsp_operand_address_and_repeat.sv
// Self-checking bench for the operand address and repeat block.
// Assumes the design package and top module are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_dsp_operand_address_and_repeat;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pv = 1'b0;
  dsp_addr_pkg::prog_t pword = '0;
  logic pready;
  logic [15:0] mrd = 16'h0000;
  logic [15:0] rop = 16'h0000;
  dsp_addr_pkg::op_result_t res;
  logic hold;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic ack;
  logic [31:0] rdat;
  int err_count = 0;
  int n_compared = 0;

  dsp_operand_address_and_repeat uut (
    .CORE_CLK(clk), .RESET_N(rst_n), .PROG_VALID(pv), .PROG_WORD(pword),
    .PROG_READY(pready), .MEM_RDATA(mrd), .REG_OPERAND(rop),
    .OP_RESULT(res), .INT_HOLD(hold), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_ACK_O(ack), .WB_DAT_O(rdat)
  );

  // 50 MHz core clock
  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    err_count++;
    $display("mismatch %s expected answer seen timeout", nm);
    print_verdict();
  endtask

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) hang("bus ack");
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Offer one program word until taken
  task automatic send(input dsp_addr_pkg::prog_t w);
    int i;
    @(posedge clk);
    pv <= 1'b1;
    pword <= w;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 40) hang("prog ready");
    pv <= 1'b0;
  endtask

  // Cycles until the next result pulse
  task automatic get_res(output int n);
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (res.addr_valid === 1'b1 || res.data_valid === 1'b1) break;
    end
    if (n == 40) hang("operand result");
  endtask

  function automatic dsp_addr_pkg::prog_t pw(input logic [1:0] m,
      input logic li, input logic rp, input logic [15:0] w);
    pw = {m, li, rp, w};
  endfunction

  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev[i] = v[15-i];
  endfunction

  function automatic logic [15:0] upd(input logic [2:0] c,
      input logic [15:0] a, input logic [15:0] x);
    case (c)
      3'h1: upd = a + 16'h0001;
      3'h2: upd = a - 16'h0001;
      3'h3: upd = a + x;
      3'h4: upd = a - x;
      3'h5: upd = rev(rev(a) + rev(x));
      3'h6: upd = rev(rev(a) - rev(x));
      default: upd = a;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [15:0] c;
    logic [15:0] x;
    logic [8:0] pg;
    logic [2:0] s;
    logic [2:0] ns;
    int n;
    int n0;
    int np;
    int f;
    int l;
    int hs;
    void'($urandom(32'h5a6f));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, dsp_addr_pkg::REG_STATUS, 32'h0, rd);
    chk("status reset", 32'h0, rd);
    wb(1'b0, dsp_addr_pkg::REG_WAIT, 32'h0, rd);
    chk("wait reset", 32'h7, rd);
    wb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    // Off-chip access then a short immediate; each wait state costs one cycle
    wb(1'b1, dsp_addr_pkg::REG_CTRL, 32'h000001FF, rd);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wb(1'b1, dsp_addr_pkg::REG_WAIT, 32'h0, rd);
      send(pw(2'h0, 1'b0, 1'b0, 16'h0005));
      send(pw(2'h2, 1'b0, 1'b0, 16'h0011));
      get_res(n);
      if (k == 0) n0 = n;
    end
    chk("offchip stall", 32'(n0 - 7), 32'(n));
    // Direct addresses from random pages and offsets
    repeat (4) begin
      pg = 9'($urandom);
      c = 16'($urandom);
      wb(1'b1, dsp_addr_pkg::REG_CTRL, 32'(pg), rd);
      send(pw(2'h0, 1'b0, 1'b0, {9'h000, c[6:0]}));
      get_res(n);
      chk("direct addr", 32'({pg, c[6:0]}), 32'(res.addr));
    end
    // Every indirect update code
    for (int k = 0; k < 8; k++) begin
      s = 3'(1 + $urandom % 7);
      ns = 3'($urandom);
      c = 16'($urandom);
      x = 16'($urandom);
      wb(1'b1, dsp_addr_pkg::REG_AUX_BASE, 32'(x), rd);
      wb(1'b1, 8'(32'h20 + 4 * s), 32'(c), rd);
      wb(1'b1, dsp_addr_pkg::REG_CTRL, {13'h0, s, 16'h0}, rd);
      send(pw(2'h1, 1'b0, 1'b0, {9'h000, 3'(k), 1'b1, ns}));
      get_res(n);
      chk("indirect addr", 32'(c), 32'(res.addr));
      wb(1'b0, 8'(32'h20 + 4 * s), 32'h0, rd);
      chk("aux update", 32'(upd(3'(k), c, x)), rd);
      wb(1'b0, dsp_addr_pkg::REG_CTRL, 32'h0, rd);
      chk("selector load", 32'(ns), 32'(rd[18:16]));
    end
    // Short, long and register operands
    c = 16'($urandom);
    x = 16'($urandom);
    send(pw(2'h2, 1'b0, 1'b0, c));
    get_res(n);
    chk("short imm", 32'(c[7:0]), 32'(res.data));
    send(pw(2'h2, 1'b1, 1'b0, c));
    send(pw(2'h2, 1'b0, 1'b0, x));
    get_res(n);
    chk("long imm", 32'(x), 32'(res.data));
    rop <= c;
    send(pw(2'h3, 1'b0, 1'b0, 16'h0000));
    get_res(n);
    chk("register op", 32'(c), 32'(res.data));
    // Repeat loaded by immediate, direct and indirect forms
    wb(1'b1, dsp_addr_pkg::REG_CTRL, 32'h0, rd);
    for (int k = 0; k < 3; k++) begin
      x = (k == 0) ? 16'h0000 : 16'(1 + $urandom % 6);
      mrd <= x;
      c = (k == 0) ? x : 16'h0005;
      send(pw(2'(k == 0 ? 2 : k - 1), 1'b0, 1'b1, c));
      send(pw(2'h2, 1'b0, 1'b0, 16'h0042));
      np = 0;
      f = -1;
      l = 0;
      hs = 0;
      for (int i = 0; i < 40; i++) begin
        @(negedge clk);
        if (hold === 1'b1) hs = 1;
        if (res.data_valid === 1'b1) begin
          np++;
          if (f < 0) f = i;
          l = i;
        end
      end
      chk("repeat count", 32'(x) + 1, 32'(np));
      chk("iteration spacing", 32'(x), 32'(l - f));
      chk("hold during loop", 32'h1, 32'(hs));
      chk("hold released", 32'h0, 32'(hold));
    end
    // Armed repeat cleared by a reset before its repeated instruction arrives
    send(pw(2'h2, 1'b0, 1'b1, 16'h0005));
    wb(1'b0, dsp_addr_pkg::REG_STATUS, 32'h0, rd);
    chk("counter loaded", 32'h5, 32'(rd[15:0]));
    chk("hold armed", 32'h1, 32'(rd[17]));
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, dsp_addr_pkg::REG_STATUS, 32'h0, rd);
    chk("counter cleared", 32'h0, rd);
    print_verdict();
  end
endmodule

`default_nettype wire
